// ==== rtl/rsi_top.sv ====
// Reset state initializer: control bits with defined start values,
// memory placement, a small timer, clock output divider and shifter.
// Assumes a classic Wishbone master on clk_i; pins arrive unsynchronised.
//
// Notes on behaviour
// R1: Clock out divides by 1,4,6,8
// R2: Shift order LSB first when select set
// R3: Extra rate bit adds divide by four
// R4: Reset sets X, I and S bits
// R5: Register block position resets to zero
// R6: RAM placed at 0x0080 after reset
// R7: EEPROM position zero, block at 0x0d80
// R8: Timer count zero, compares all ones
// R9: Compare pin mask cleared, captures disabled
// R10: Timer flags and enables cleared on reset
// R11: Capture4/compare5 select cleared, pin undriven
// R12: Periodic enable and rate bits cleared
// R13: Pulse accumulator off, line 7 input
// R14: Watchdog follows disable bit, rate zero
// R15: Baud loads 0x0004, serial disabled
// R16: Eight-bit frames, no break or wake-up
// R17: Transmit flags set, receive flags clear
// R18: Shifter off, converter power and flag clear
// R19: Priority select loads 00110 on reset
// R20: Mode bits capture mode pins at release
// R21: Level request, delay set, monitor off
// R22: Maskable needs I clear, non-maskable needs X clear
`timescale 1ns/1ps
module rsi_top
  import rsi_pkg::*;
#(
  parameter logic [7:0] CONFIG_RESET = 8'h00,
  parameter bit SMALL_RAM = 1'b0
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic nonmaskable_request_pin_n_i,
  input wire logic spi_miso_i,
  output logic spi_sck_o,
  output logic spi_mosi_o,
  output logic clock_out_pin_o,
  // Interrupt recognition
  input wire logic [18:0] maskable_src_i,
  output logic maskable_pending_o,
  output logic nonmaskable_pending_o,
  // Memory decode
  input wire logic [15:0] cpu_addr_i,
  output logic reg_hit_o,
  output logic ram_hit_o,
  output logic eeprom_hit_o,
  // Peripheral state
  output logic watchdog_enable_o,
  output logic [1:0] watchdog_rate_select_o,
  output logic clock_monitor_on_o,
  output logic irq_edge_mode_o,
  output logic stop_recovery_delay_o,
  output logic port_a_line3_driven_o,
  output logic pulse_accum_input_o
);
  logic [7:0] choices2_ff, ccr_ff, regpos_ff, eepos_ff, config_ff;
  logic [7:0] option_ff, tmask2_ff, pulse_accumulator_control_ff, timer_control_first_ff, output_compare1_pin_mask_ff;
  logic [7:0] scctl_ff, spctl_ff, converter_control_ff, spdat_ff, spshift_ff;
  logic [15:0] baud_ff, tcount_ff;
  logic [15:0] oc_ff [NUM_OC];
  logic [8:0] tflags_ff, tmask_ff, nxt_tflags;
  logic [4:0] psel_ff;
  logic [2:0] mode_ff;
  logic [3:0] prescale_ff;
  logic [31:0] rd_word;
  logic ack_ff, req, wr, rst_q_ff, tick;
  logic [1:0] mda_sync_ff, mdb_sync_ff, nmi_sync_ff, miso_sync_ff;

  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & ack_ff & wb_sel_i[0];

  function automatic logic hit(input logic [7:0] ofs);
    hit = wr & (wb_adr_i == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, write at the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_ff <= req & ~ack_ff;
      if (req & ~ack_ff) begin
        wb_dat_o <= rd_word;
      end
    end
  end
  assign wb_ack_o = ack_ff;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_CHOICES2: rd_word[7:0] = choices2_ff;
      OFS_CCR: rd_word[7:0] = ccr_ff;
      OFS_REGPOS: rd_word[7:0] = regpos_ff;
      OFS_EEPOS: rd_word[7:0] = eepos_ff;
      OFS_CONFIG: rd_word[7:0] = config_ff;
      OFS_OPTION: rd_word[7:0] = option_ff;
      OFS_PRIO: rd_word[7:0] = {mode_ff, psel_ff};
      OFS_TCOUNT: rd_word[15:0] = tcount_ff;
      OFS_TFLAGS: rd_word[8:0] = tflags_ff;
      OFS_TMASK: rd_word[8:0] = tmask_ff;
      OFS_TMASK2: rd_word[7:0] = tmask2_ff;
      OFS_PULSE_ACCUMULATOR_CONTROL: rd_word[7:0] = pulse_accumulator_control_ff;
      OFS_TIMER_CONTROL_FIRST: rd_word[7:0] = timer_control_first_ff;
      OFS_OUTPUT_COMPARE1_PIN_MASK: rd_word[7:0] = output_compare1_pin_mask_ff;
      OFS_BAUD: rd_word[15:0] = baud_ff;
      OFS_SCCTL: rd_word[7:0] = scctl_ff;
      OFS_SCSTAT: rd_word[7:0] = RST_SCSTAT; // R17
      OFS_SPCTL: rd_word[7:0] = spctl_ff;
      OFS_SPDAT: rd_word[7:0] = spdat_ff;
      OFS_CONVERTER_CONTROL: rd_word[7:0] = converter_control_ff;
      default: begin
        for (int k = 0; k < NUM_OC; k++) begin
          if (wb_adr_i == OFS_OC_BASE + 8'(4 * k)) begin
            rd_word[15:0] = oc_ff[k];
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_sync_ff <= 2'h3;
      miso_sync_ff <= 2'h0;
    end else if (ce_i) begin
      nmi_sync_ff <= {nmi_sync_ff[0], nonmaskable_request_pin_n_i};
      miso_sync_ff <= {miso_sync_ff[0], spi_miso_i};
    end
  end

  // Mode pins sample through reset so their level is ready at release
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      mda_sync_ff <= {mda_sync_ff[0], mode_pin_a_i};
      mdb_sync_ff <= {mdb_sync_ff[0], mode_pin_b_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU mask bits, placement, system options
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ccr_ff <= RST_CCR; // R4
      regpos_ff <= 8'h00; // R5
      eepos_ff <= 8'h00; // R7
      choices2_ff <= 8'h00;
      option_ff <= RST_OPTION; // R14 R18 R21
      config_ff <= CONFIG_RESET;
      psel_ff <= RST_PSEL; // R19
    end else if (ce_i) begin
      // X may be cleared by software but never set again
      if (hit(OFS_CCR)) begin
        ccr_ff <= {wb_dat_i[7], ccr_ff[CCR_X] & wb_dat_i[6], wb_dat_i[5:0]};
      end
      if (hit(OFS_REGPOS)) regpos_ff <= wb_dat_i[7:0];
      if (hit(OFS_EEPOS)) eepos_ff <= wb_dat_i[7:0];
      if (hit(OFS_CHOICES2)) choices2_ff <= wb_dat_i[7:0];
      if (hit(OFS_CONFIG)) config_ff <= wb_dat_i[7:0];
      // Force monitor stays on until the next reset
      if (hit(OFS_OPTION)) begin
        option_ff <= wb_dat_i[7:0] | (option_ff & 8'(1 << OPT_CLOCK_MONITOR_FORCE));
      end
      if (hit(OFS_PRIO)) psel_ff <= wb_dat_i[4:0];
    end
  end

  // Mode levels taken on the first cycle after reset release
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_q_ff <= 1'b1;
      mode_ff <= 3'h0;
    end else if (ce_i) begin
      rst_q_ff <= 1'b0;
      if (rst_q_ff) begin
        mode_ff <= {~mdb_sync_ff[1] & ~mda_sync_ff[1], ~mdb_sync_ff[1],
                    mda_sync_ff[1]}; // R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer: prescaled count, compares, flags with set winning over clear
  always_comb begin
    nxt_tflags = tflags_ff;
    if (hit(OFS_TFLAGS)) nxt_tflags = tflags_ff & ~wb_dat_i[8:0];
    if (tick) begin
      for (int k = 0; k < NUM_OC; k++) begin
        if (tcount_ff == oc_ff[k]) nxt_tflags[7 - k] = 1'b1;
      end
      if (tcount_ff == 16'hffff) nxt_tflags[8] = 1'b1;
    end
  end

  always_comb begin
    unique case (tmask2_ff[1:0])
      2'h0: tick = 1'b1;
      2'h1: tick = prescale_ff[1:0] == 2'h3;
      2'h2: tick = prescale_ff[2:0] == 3'h7;
      2'h3: tick = prescale_ff == 4'hf;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcount_ff <= 16'h0000; // R8
      prescale_ff <= 4'h0;
      tflags_ff <= 9'h000; // R10
      tmask_ff <= 9'h000; // R10
      tmask2_ff <= 8'h00; // R8 R12
      pulse_accumulator_control_ff <= 8'h00; // R11 R12 R13
      timer_control_first_ff <= 8'h00; // R9 R11
      output_compare1_pin_mask_ff <= 8'h00; // R9
    end else if (ce_i) begin
      prescale_ff <= prescale_ff + 4'h1;
      if (tick) tcount_ff <= tcount_ff + 16'h0001;
      tflags_ff <= nxt_tflags;
      if (hit(OFS_TMASK)) tmask_ff <= wb_dat_i[8:0];
      if (hit(OFS_TMASK2)) tmask2_ff <= wb_dat_i[7:0];
      if (hit(OFS_PULSE_ACCUMULATOR_CONTROL)) pulse_accumulator_control_ff <= wb_dat_i[7:0];
      if (hit(OFS_TIMER_CONTROL_FIRST)) timer_control_first_ff <= wb_dat_i[7:0];
      if (hit(OFS_OUTPUT_COMPARE1_PIN_MASK)) output_compare1_pin_mask_ff <= wb_dat_i[7:0];
    end
  end

  for (genvar g = 0; g < NUM_OC; g++) begin : g_oc
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        oc_ff[g] <= RST_OC; // R8
      end else if (ce_i && wr && wb_adr_i == OFS_OC_BASE + 8'(4 * g)) begin
        oc_ff[g] <= wb_dat_i[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial and converter control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_ff <= RST_BAUD; // R15
      scctl_ff <= 8'h00; // R15 R16
      spctl_ff <= 8'h00; // R18
      converter_control_ff <= 8'h00; // R18
    end else if (ce_i) begin
      if (hit(OFS_BAUD)) baud_ff <= wb_dat_i[15:0];
      if (hit(OFS_SCCTL)) scctl_ff <= wb_dat_i[7:0];
      if (hit(OFS_SPCTL)) spctl_ff <= wb_dat_i[7:0];
      if (hit(OFS_CONVERTER_CONTROL)) converter_control_ff <= {1'b0, wb_dat_i[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shifter: one byte per data write, idle clock low
  logic [6:0] sp_half, sp_cnt_ff;
  logic [3:0] sp_bits_ff;
  logic sp_busy_ff, sp_sck_ff, sp_lsb;
  assign sp_lsb = choices2_ff[CH2_LSB_FIRST_SELECT];
  always_comb begin
    unique case (spctl_ff[1:0])
      2'h0: sp_half = 7'h01;
      2'h1: sp_half = 7'h02;
      2'h2: sp_half = 7'h08;
      2'h3: sp_half = 7'h10;
    endcase
    // Extra stage costs slower reprogramming but frees a rate code
    if (choices2_ff[CH2_XTRA]) begin
      sp_half = 7'(sp_half * SPI_EXTRA_DIV); // R3
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sp_busy_ff <= 1'b0;
      sp_sck_ff <= 1'b0;
      sp_cnt_ff <= 7'h00;
      sp_bits_ff <= 4'h0;
      spshift_ff <= 8'h00;
      spdat_ff <= 8'h00;
    end else if (ce_i) begin
      if (!sp_busy_ff) begin
        if (hit(OFS_SPDAT) && spctl_ff[SPC_EN]) begin
          spshift_ff <= wb_dat_i[7:0];
          sp_busy_ff <= 1'b1;
          sp_cnt_ff <= 7'h00;
          sp_bits_ff <= 4'h0;
        end
      end else if (sp_cnt_ff == sp_half - 7'h01) begin
        sp_cnt_ff <= 7'h00;
        sp_sck_ff <= ~sp_sck_ff;
        if (sp_sck_ff) begin
          if (sp_lsb) begin
            spshift_ff <= {miso_sync_ff[1], spshift_ff[7:1]}; // R2
          end else begin
            spshift_ff <= {spshift_ff[6:0], miso_sync_ff[1]}; // R2
          end
          sp_bits_ff <= sp_bits_ff + 4'h1;
          if (sp_bits_ff == 4'h7) begin
            sp_busy_ff <= 1'b0;
            spdat_ff <= sp_lsb ? {miso_sync_ff[1], spshift_ff[7:1]} :
                                 {spshift_ff[6:0], miso_sync_ff[1]};
          end
        end
      end else begin
        sp_cnt_ff <= sp_cnt_ff + 7'h01;
      end
    end
  end
  assign spi_sck_o = sp_sck_ff;
  assign spi_mosi_o = sp_lsb ? spshift_ff[0] : spshift_ff[7]; // R2

  ////////////////////////////////////////////////////////////////////////
  // Clock output divider; divide by one passes the crystal clock gated
  logic [1:0] xo_cnt_ff, xo_half;
  logic xo_ff, xo_en;
  assign xo_en = config_ff[CFG_CLOCK_OUT_ENABLE];
  always_comb begin
    unique case (choices2_ff[1:0])
      2'h1: xo_half = XO_HALF4;
      2'h2: xo_half = XO_HALF6;
      default: xo_half = XO_HALF8;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xo_cnt_ff <= 2'h0;
      xo_ff <= 1'b0;
    end else if (ce_i) begin
      if (!xo_en) begin
        xo_cnt_ff <= 2'h0;
        xo_ff <= 1'b0;
      // At or past the end: a shorter code chosen mid period wraps at once
      end else if (xo_cnt_ff >= xo_half - 2'h1) begin
        xo_cnt_ff <= 2'h0;
        xo_ff <= ~xo_ff; // R1
      end else begin
        xo_cnt_ff <= xo_cnt_ff + 2'h1;
      end
    end
  end
  // Gated clock may glitch when the select changes mid period
  assign clock_out_pin_o = !xo_en ? 1'b0 :
                           choices2_ff[1:0] == 2'h0 ? clk_i : xo_ff; // R1

  ////////////////////////////////////////////////////////////////////////
  // Interrupt recognition and peripheral state
  assign maskable_pending_o = |maskable_src_i & ~ccr_ff[CCR_I]; // R22
  assign nonmaskable_pending_o = ~nmi_sync_ff[1] & ~ccr_ff[CCR_X]; // R22
  assign watchdog_enable_o = ~config_ff[CFG_WDOFF]; // R14
  assign watchdog_rate_select_o = option_ff[1:0]; // R14
  assign clock_monitor_on_o = option_ff[OPT_CME] | option_ff[OPT_CLOCK_MONITOR_FORCE];
  assign irq_edge_mode_o = option_ff[OPT_IRQE]; // R21
  assign stop_recovery_delay_o = option_ff[OPT_DLY]; // R21
  assign port_a_line3_driven_o = ~pulse_accumulator_control_ff[PAC_I4O5] &
                                 (|timer_control_first_ff[1:0]); // R11
  assign pulse_accum_input_o = ~pulse_accumulator_control_ff[PAC_EN]; // R13
  assign reg_hit_o = (cpu_addr_i - {regpos_ff[3:0], 12'h000}) <=
                     REG_SPAN; // R5
  assign ram_hit_o = (cpu_addr_i >= {regpos_ff[7:4], 12'h000} + RAM_FIRST)
                   & (cpu_addr_i <= {regpos_ff[7:4], 12'h000} +
                      (SMALL_RAM ? RAM_LAST_SMALL : RAM_LAST_FULL)); // R6
  assign eeprom_hit_o = (cpu_addr_i - ({eepos_ff[7:4], 12'h000} +
                        EE_FIRST)) <= EE_SPAN; // R7

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_ccr_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ccr_ff == RST_CCR) else $error("ccr reset"); // R4
  chk_prio_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> psel_ff == RST_PSEL) else $error("psel"); // R19
  chk_timer_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> tcount_ff == 16'h0000 && oc_ff[4] == RST_OC &&
    tflags_ff == 9'h000) else $error("timer reset"); // R8
  chk_option_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> stop_recovery_delay_o && !clock_monitor_on_o &&
    !irq_edge_mode_o) else $error("option reset"); // R21
  chk_serial_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> baud_ff == RST_BAUD && scctl_ff == 8'h00)
    else $error("serial reset"); // R15
  chk_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && tick && tcount_ff == oc_ff[0] |=> tflags_ff[7])
    else $error("compare flag lost"); // R10
  chk_mode_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && rst_q_ff |=> mode_ff[0] == $past(mda_sync_ff[1]))
    else $error("mode capture"); // R20
  chk_xo_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    xo_en && choices2_ff[1:0] == 2'h1 && ce_i && $stable(choices2_ff)
    |-> xo_cnt_ff <= 2'h1) else $error("clock out divide"); // R1
  chk_nmi_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ccr_ff[CCR_X] |-> !nonmaskable_pending_o) else $error("nmi"); // R22
  chk_shift_len: assert property (@(posedge clk_i) disable iff (rst_i)
    sp_busy_ff |-> sp_bits_ff <= 4'h7) else $error("shift length"); // R2
  cov_shift: cover property (@(posedge clk_i) $fell(sp_busy_ff));
  cov_overflow: cover property (@(posedge clk_i) $rose(tflags_ff[8]));
  cov_clear_x: cover property (@(posedge clk_i) $fell(ccr_ff[CCR_X]));
endmodule

// ==== shared/rsi_pkg.sv ====
// Constants for the reset state initializer: register map, reset values
// and divider figures. Assumes a 32-bit classic Wishbone register bus.
package rsi_pkg;
  // Byte offsets, one aligned word each
  localparam logic [7:0] OFS_CHOICES2 = 8'h00;
  localparam logic [7:0] OFS_CCR = 8'h04;
  localparam logic [7:0] OFS_REGPOS = 8'h08;
  localparam logic [7:0] OFS_EEPOS = 8'h0c;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_OPTION = 8'h14;
  localparam logic [7:0] OFS_PRIO = 8'h18;
  localparam logic [7:0] OFS_TCOUNT = 8'h1c;
  localparam logic [7:0] OFS_TFLAGS = 8'h20;
  localparam logic [7:0] OFS_TMASK = 8'h24;
  localparam logic [7:0] OFS_TMASK2 = 8'h28;
  localparam logic [7:0] OFS_PULSE_ACCUMULATOR_CONTROL = 8'h2c;
  localparam logic [7:0] OFS_TIMER_CONTROL_FIRST = 8'h30;
  localparam logic [7:0] OFS_OUTPUT_COMPARE1_PIN_MASK = 8'h34;
  localparam logic [7:0] OFS_BAUD = 8'h38;
  localparam logic [7:0] OFS_SCCTL = 8'h3c;
  localparam logic [7:0] OFS_SCSTAT = 8'h40;
  localparam logic [7:0] OFS_SPCTL = 8'h44;
  localparam logic [7:0] OFS_SPDAT = 8'h48;
  localparam logic [7:0] OFS_CONVERTER_CONTROL = 8'h4c;
  localparam logic [7:0] OFS_OC_BASE = 8'h50;
  // Reset values
  localparam logic [7:0] RST_CCR = 8'hd0;
  localparam logic [7:0] RST_OPTION = 8'h10;
  localparam logic [4:0] RST_PSEL = 5'h06;
  localparam logic [15:0] RST_BAUD = 16'h0004;
  localparam logic [7:0] RST_SCSTAT = 8'hc0;
  localparam logic [15:0] RST_OC = 16'hffff;
  // Field positions
  localparam int CCR_S = 7;
  localparam int CCR_X = 6;
  localparam int CCR_I = 4;
  localparam int OPT_CONVERTER_POWER_UP = 7;
  localparam int OPT_IRQE = 5;
  localparam int OPT_DLY = 4;
  localparam int OPT_CME = 3;
  localparam int OPT_CLOCK_MONITOR_FORCE = 2;
  localparam int CH2_LSB_FIRST_SELECT = 7;
  localparam int CH2_XTRA = 6;
  localparam int CFG_CLOCK_OUT_ENABLE = 1;
  localparam int CFG_WDOFF = 0;
  localparam int PAC_EN = 6;
  localparam int PAC_I4O5 = 2;
  localparam int SPC_EN = 6;
  localparam int TMK2_PIE = 6;
  localparam int NUM_OC = 5;
  // Memory placement
  localparam logic [15:0] RAM_FIRST = 16'h0080;
  localparam logic [15:0] RAM_LAST_FULL = 16'h067f;
  localparam logic [15:0] RAM_LAST_SMALL = 16'h047f;
  localparam logic [15:0] REG_SPAN = 16'h007f;
  localparam logic [15:0] EE_FIRST = 16'h0d80;
  localparam logic [15:0] EE_SPAN = 16'h027f;
  // Divider half periods and shifter extra divide factor
  localparam logic [1:0] XO_HALF4 = 2'h2;
  localparam logic [1:0] XO_HALF6 = 2'h3;
  localparam logic [1:0] XO_HALF8 = 2'h0;
  localparam int SPI_EXTRA_DIV = 4;
endpackage

// ==== verification/rsi_top_tb.sv ====
// Self-checking bench for the reset state initializer top.
// Assumes rsi_pkg compiled first; the bench is the only bus master.
`timescale 1ns/1ps
module rsi_top_tb;
  import rsi_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [31:0] exp;} rsi_row_s;
  typedef struct packed {logic [15:0] adr; logic [2:0] hit;} rsi_dec_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, spi_sck_o, spi_mosi_o, clock_out_pin_o;
  logic mode_pin_a_i = 1'b0, mode_pin_b_i = 1'b0;
  // Pin held low and two sources raised from the start: masks must hold them
  logic nonmaskable_request_pin_n_i = 1'b0;
  logic spi_miso_i = 1'b1;
  logic [18:0] maskable_src_i = 19'h40001;
  logic maskable_pending_o, nonmaskable_pending_o;
  logic [15:0] cpu_addr_i = 16'h0000;
  logic reg_hit_o, ram_hit_o, eeprom_hit_o;
  logic watchdog_enable_o, clock_monitor_on_o, irq_edge_mode_o;
  logic stop_recovery_delay_o, port_a_line3_driven_o, pulse_accum_input_o;
  logic [1:0] watchdog_rate_select_o;
  int error_cnt = 0;
  int n_tests = 0;
  int xdiv [4] = '{1, 4, 6, 8};
  rsi_row_s rows [17] = '{
    '{OFS_CCR, {24'h0, RST_CCR}},
    '{OFS_REGPOS, 32'h0},
    '{OFS_EEPOS, 32'h0},
    '{OFS_CONFIG, 32'h0},
    '{OFS_OPTION, {24'h0, RST_OPTION}},
    '{OFS_TFLAGS, 32'h0},
    '{OFS_TMASK, 32'h0},
    '{OFS_TMASK2, 32'h0},
    '{OFS_PULSE_ACCUMULATOR_CONTROL, 32'h0},
    '{OFS_TIMER_CONTROL_FIRST, 32'h0},
    '{OFS_OUTPUT_COMPARE1_PIN_MASK, 32'h0},
    '{OFS_BAUD, {16'h0, RST_BAUD}},
    '{OFS_SCCTL, 32'h0},
    '{OFS_SCSTAT, {24'h0, RST_SCSTAT}},
    '{OFS_SPCTL, 32'h0},
    '{OFS_CONVERTER_CONTROL, 32'h0},
    '{8'hfc, 32'h0}
  };
  rsi_dec_s decs [9] = '{
    '{16'h0000, 3'b100}, '{16'h007f, 3'b100},
    '{16'h0080, 3'b010}, '{16'h067f, 3'b010},
    '{16'h0680, 3'b000}, '{16'h0d7f, 3'b000},
    '{16'h0d80, 3'b001}, '{16'h0fff, 3'b001},
    '{16'h1000, 3'b000}
  };

  always #2 clk_i = ~clk_i;

  rsi_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mode_pin_a_i(mode_pin_a_i), .mode_pin_b_i(mode_pin_b_i),
    .nonmaskable_request_pin_n_i(nonmaskable_request_pin_n_i),
    .spi_miso_i(spi_miso_i), .spi_sck_o(spi_sck_o),
    .spi_mosi_o(spi_mosi_o), .clock_out_pin_o(clock_out_pin_o),
    .maskable_src_i(maskable_src_i),
    .maskable_pending_o(maskable_pending_o),
    .nonmaskable_pending_o(nonmaskable_pending_o),
    .cpu_addr_i(cpu_addr_i), .reg_hit_o(reg_hit_o),
    .ram_hit_o(ram_hit_o), .eeprom_hit_o(eeprom_hit_o),
    .watchdog_enable_o(watchdog_enable_o),
    .watchdog_rate_select_o(watchdog_rate_select_o),
    .clock_monitor_on_o(clock_monitor_on_o),
    .irq_edge_mode_o(irq_edge_mode_o),
    .stop_recovery_delay_o(stop_recovery_delay_o),
    .port_a_line3_driven_o(port_a_line3_driven_o),
    .pulse_accum_input_o(pulse_accum_input_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (error_cnt == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %0t: period %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    error_cnt++;
    $display("Error %0t: no %s in time", $time, what);
    tally_and_finish();
  endtask

  task automatic do_reset(input logic a, input logic b);
    rst_i <= 1'b1;
    mode_pin_a_i <= a;
    mode_pin_b_i <= b;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Classic single cycle; released only at the edge that samples ack
  task automatic wb_xfer(input logic we, input logic [7:0] a,
                         input logic [31:0] d, input logic [3:0] sel,
                         output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) give_up("ack");
  endtask

  // Returns edges counted up to the next sampled rise of s
  task automatic wait_rise(ref logic s, output int n);
    logic p;
    n = 0;
    do begin
      p = s;
      @(posedge clk_i);
      n++;
    end while (!(p === 1'b0 && s === 1'b1) && n < 100);
    if (n >= 100) give_up("edge");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic check_rows(input logic a, input logic b);
    logic [31:0] q;
    foreach (rows[i]) begin
      wb_xfer(1'b0, rows[i].adr, 32'h0, 4'hf, q);
      cmp_word(q, rows[i].exp);
    end
    for (int k = 0; k < NUM_OC; k++) begin
      wb_xfer(1'b0, OFS_OC_BASE + 8'(4 * k), 32'h0, 4'hf, q);
      cmp_word(q, {16'h0, RST_OC});
    end
    wb_xfer(1'b0, OFS_PRIO, 32'h0, 4'hf, q);
    cmp_word(q, {24'h0, ~b & ~a, ~b, a, RST_PSEL});
    cmp_word({21'h0, watchdog_enable_o, watchdog_rate_select_o,
      clock_monitor_on_o, irq_edge_mode_o, stop_recovery_delay_o,
      port_a_line3_driven_o, pulse_accum_input_o, clock_out_pin_o,
      maskable_pending_o, nonmaskable_pending_o},
      32'h0000_0428);
  endtask

  task automatic shift_check(input logic lsb, input logic xtra,
                             input logic [7:0] d);
    logic [31:0] q;
    logic [7:0] got;
    int n;
    int per;
    wb_xfer(1'b1, OFS_CHOICES2, {24'h0, lsb, xtra, 6'h0}, 4'hf, q);
    wb_xfer(1'b1, OFS_SPCTL, 32'h40, 4'hf, q);
    wb_xfer(1'b1, OFS_SPDAT, {24'h0, d}, 4'hf, q);
    for (int i = 0; i < 8; i++) begin
      wait_rise(spi_sck_o, n);
      if (i == 1) per = n;
      got[lsb ? i : 7 - i] = spi_mosi_o;
    end
    cmp_cnt(per, xtra ? 8 : 2);
    cmp_word({24'h0, got}, {24'h0, d});
    // No busy flag at the ports, so allow the last half period to finish
    repeat (40) @(posedge clk_i);
    wb_xfer(1'b0, OFS_SPDAT, 32'h0, 4'hf, q);
    cmp_word(q, 32'hff);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    int n;
    do_reset(1'b1, 1'b0);
    check_rows(1'b1, 1'b0);
    foreach (decs[i]) begin
      @(posedge clk_i);
      cpu_addr_i <= decs[i].adr;
      @(negedge clk_i);
      cmp_word({29'h0, reg_hit_o, ram_hit_o, eeprom_hit_o},
        {29'h0, decs[i].hit});
    end
    wb_xfer(1'b1, OFS_CCR, 32'hc0, 4'hf, q);
    @(negedge clk_i);
    cmp_word({31'h0, maskable_pending_o}, 32'h1);
    cmp_word({31'h0, nonmaskable_pending_o}, 32'h0);
    wb_xfer(1'b1, OFS_CCR, 32'h80, 4'hf, q);
    wb_xfer(1'b1, OFS_CCR, 32'hc0, 4'hf, q);
    wb_xfer(1'b0, OFS_CCR, 32'h0, 4'hf, q);
    cmp_word(q, 32'hc0 & ~(32'h1 << CCR_X));
    cmp_word({31'h0, nonmaskable_pending_o}, 32'h1);
    wb_xfer(1'b1, OFS_CONFIG, 32'h1 << CFG_CLOCK_OUT_ENABLE, 4'hf, q);
    wb_xfer(1'b1, OFS_CHOICES2, 32'h0, 4'hf, q);
    @(posedge clk_i);
    #1 cmp_word({31'h0, clock_out_pin_o}, 32'h1);
    @(negedge clk_i);
    #1 cmp_word({31'h0, clock_out_pin_o}, 32'h0);
    for (int c = 1; c < 4; c++) begin
      wb_xfer(1'b1, OFS_CHOICES2, 32'(c), 4'hf, q);
      wait_rise(clock_out_pin_o, n);
      wait_rise(clock_out_pin_o, n);
      cmp_cnt(n, xdiv[c]);
    end
    shift_check(1'b0, 1'b0, 8'ha5);
    shift_check(1'b1, 1'b1, 8'h3c);
    wb_xfer(1'b1, OFS_BAUD, 32'h1234, 4'he, q);
    wb_xfer(1'b0, OFS_BAUD, 32'h0, 4'hf, q);
    cmp_word(q, {16'h0, RST_BAUD});
    wb_xfer(1'b1, OFS_BAUD, 32'h1234, 4'hf, q);
    wb_xfer(1'b1, 8'hfc, 32'h55, 4'hf, q);
    // Compare 1 just ahead of the free count must raise its flag
    wb_xfer(1'b0, OFS_TCOUNT, 32'h0, 4'hf, q);
    wb_xfer(1'b1, OFS_OC_BASE, {16'h0, q[15:0] + 16'h0040}, 4'hf, q);
    repeat (100) @(posedge clk_i);
    wb_xfer(1'b0, OFS_TFLAGS, 32'h0, 4'hf, q);
    cmp_word(q & 32'h0000_0180, 32'h0000_0080);
    // Mid-run reset with other mode pins: the row, compare, priority and port start values come back
    do_reset(1'b0, 1'b0);
    check_rows(1'b0, 1'b0);
    tally_and_finish();
  end
endmodule
